// File: emp_pkg.sv
// Purpose: Shared constants for the external memory port pin logic
// Assumes: 10 MHz ref_clk
// Notes: APB register map, field positions and reset values
package emp_pkg;
    localparam int EMP_ADDR_W = 24;
    localparam int EMP_DATA_W = 32;
    localparam int EMP_BANKS = 4;
    localparam int EMP_GPIO = 4;
    // APB byte offsets
    localparam logic [7:0] EMP_OFS_CTRL = 8'h00;
    localparam logic [7:0] EMP_OFS_CMD = 8'h04;
    localparam logic [7:0] EMP_OFS_WDATA = 8'h08;
    localparam logic [7:0] EMP_OFS_RDATA = 8'h0C;
    localparam logic [7:0] EMP_OFS_STAT = 8'h10;
    localparam logic [7:0] EMP_OFS_FLAG = 8'h14;
    localparam logic [7:0] EMP_OFS_PIN = 8'h18;
    // CTRL fields
    localparam int EMP_CTRL_PMUX_LO = 0;   // data pin mode, 2 bits
    localparam int EMP_CTRL_G2_LO = 2;     // pin 2 mode, 2 bits
    localparam int EMP_CTRL_G3_LO = 4;     // pin 3 mode, 2 bits
    localparam int EMP_CTRL_COND = 6;      // conditional access, condition false
    localparam int EMP_CTRL_BOOT = 7;      // boot from flash on bank 1
    localparam logic [31:0] EMP_CTRL_RST = 32'h0000_0000;
    // CMD fields: address in [23:0], bank in [25:24], write in [26]
    localparam int EMP_CMD_BANK_LO = 24;
    localparam int EMP_CMD_WR = 26;
    // Data pin modes
    localparam logic [1:0] EMP_PMUX_EXTERNAL_MEMORY_INTERFACE_MODE = 2'h0;
    localparam logic [1:0] EMP_PMUX_PIP = 2'h1;
    localparam logic [1:0] EMP_PMUX_FLAG = 2'h2;
    localparam logic [1:0] EMP_PMUX_PWM = 2'h3;
    // General pin modes
    localparam logic [1:0] EMP_GMODE_FLAG = 2'h0;
    localparam logic [1:0] EMP_GMODE_ALT = 2'h1;
    localparam logic [1:0] EMP_GMODE_BANK = 2'h2;
    localparam logic [23:0] EMP_ADDR_RST = 24'h00_0000;
    localparam logic [3:0] EMP_BANK_IDLE = 4'hF;
    localparam int EMP_CLK_HZ = 10_000_000;
    localparam int EMP_STROBE_NS = 100;    // least strobe width
    localparam int EMP_STROBE_CYC =
        ((EMP_STROBE_NS * (EMP_CLK_HZ / 1_000_000)) + 999) / 1000;
endpackage

// File: emp_bank_dec.sv
// Purpose: Decode a bank number into active-low bank selects
// Assumes: Combinational
// Notes: Idle forces every select high
`timescale 1ns/1ps
module emp_bank_dec
    import emp_pkg::*;
(
    input wire logic active,
    input wire logic [1:0] bank,
    output logic [EMP_BANKS-1:0] sel_n
);
    genvar g;
    generate
        for (g = 0; g < EMP_BANKS; g++)
        begin : g_sel
            assign sel_n[g] = !(active && (bank == 2'(g)));
        end
    endgenerate
endmodule // emp_bank_dec

// File: emp_pip_cap.sv
// Purpose: Input channel 0 capture of the data pins
// Assumes: Pins synchronous to ref_clk
// Notes: Holds last word and a sticky fresh flag
`timescale 1ns/1ps
module emp_pip_cap
    import emp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic [EMP_DATA_W-1:0] pins,
    input wire logic clear,
    output logic [EMP_DATA_W-1:0] word_r,
    output logic fresh_r
);
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            word_r <= 32'h0000_0000;
        else if (enable)
            word_r <= pins;
    end

    // Set wins over clear
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            fresh_r <= 1'b0;
        else if (enable)
            fresh_r <= 1'b1;
        else if (clear)
            fresh_r <= 1'b0;
    end
endmodule // emp_pip_cap

// File: emp_port.sv
// Purpose: External asynchronous memory port pins with APB control
// Assumes: One 10 MHz clock, pins synchronous to it
// Notes: One access at a time, started by a write to CMD
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module emp_port
    import emp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [EMP_ADDR_W-1:0] ext_addr,
    input wire logic [EMP_DATA_W-1:0] data_in,
    output logic [EMP_DATA_W-1:0] data_out,
    output logic [EMP_DATA_W-1:0] data_oe_n,
    input wire logic ack,
    output logic [1:0] memory_bank_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    input wire logic [EMP_GPIO-1:0] gpio_in,
    output logic [EMP_GPIO-1:0] gpio_out,
    output logic [EMP_GPIO-1:0] gpio_oe_n,
    input wire logic [EMP_DATA_W-1:0] pwm_in,
    input wire logic timer_expired_output,
    output logic [EMP_GPIO-1:0] irq_req
);
    typedef enum logic [1:0] {
        EMP_IDLE = 2'b00,
        EMP_SETUP = 2'b01,
        EMP_STROBE = 2'b10,
        EMP_DONE = 2'b11
    } emp_state_type;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // Both strobes share one decode; a false condition leaves them high
    function automatic logic strobe_on(input emp_state_type s, input logic want_wr,
        input logic is_wr, input logic skip);
        strobe_on = (s == EMP_STROBE) && (want_wr == is_wr) && !skip;
    endfunction

    emp_state_type state_r;
    logic [31:0] ctrl_r;
    logic [31:0] wdata_r;
    logic [31:0] rdata_r;
    logic [EMP_ADDR_W-1:0] addr_r;
    logic [1:0] bank_r;
    logic wr_r;
    logic cond_r;
    logic [3:0] wait_r;
    logic [EMP_GPIO-1:0] flag_out_r;
    logic [EMP_GPIO-1:0] flag_dir_r;
    logic [EMP_DATA_W-1:0] dflag_r;
    logic [EMP_DATA_W-1:0] dflag_dir_r;
    logic active;
    logic [3:0] bank_sel_n;
    logic [1:0] pmux;
    logic [1:0] g2_mode;
    logic [1:0] g3_mode;
    logic apb_wr;
    logic apb_rd;
    logic busy;
    logic [EMP_DATA_W-1:0] pip_word;
    logic pip_fresh;
    logic [31:0] rd_mux;
    logic known;
    logic last_cyc;
    logic [EMP_DATA_W-1:0] data_out_nxt;
    logic [EMP_DATA_W-1:0] data_oe_n_nxt;
    logic [EMP_GPIO-1:0] irq_req_nxt;

    assign pmux = ctrl_r[EMP_CTRL_PMUX_LO +: 2];
    assign g2_mode = ctrl_r[EMP_CTRL_G2_LO +: 2];
    assign g3_mode = ctrl_r[EMP_CTRL_G3_LO +: 2];
    assign busy = (state_r != EMP_IDLE);
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign last_cyc = (state_r == EMP_STROBE) && (wait_r <= 4'h1) && ack;
    assign known = hit(paddr, EMP_OFS_CTRL) || hit(paddr, EMP_OFS_CMD)
        || hit(paddr, EMP_OFS_WDATA) || hit(paddr, EMP_OFS_RDATA)
        || hit(paddr, EMP_OFS_STAT) || hit(paddr, EMP_OFS_FLAG)
        || hit(paddr, EMP_OFS_PIN);
    // Command while busy is refused with an error rather than queued
    assign pslverr = psel && penable && (!known
        || (pwrite && hit(paddr, EMP_OFS_CMD) && busy));

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            ctrl_r <= EMP_CTRL_RST;
        else if (apb_wr && hit(paddr, EMP_OFS_CTRL))
            ctrl_r <= {24'h00_0000, pwdata[7:0]};
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            wdata_r <= 32'h0000_0000;
        else if (apb_wr && hit(paddr, EMP_OFS_WDATA))
            wdata_r <= pwdata;
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            flag_out_r <= 4'h0;
            flag_dir_r <= 4'h0;
        end
        else if (apb_wr && hit(paddr, EMP_OFS_FLAG))
        begin
            flag_out_r <= pwdata[3:0];
            flag_dir_r <= pwdata[7:4];
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            dflag_r <= 32'h0000_0000;
            dflag_dir_r <= 32'h0000_0000;
        end
        else if (apb_wr && hit(paddr, EMP_OFS_PIN))
        begin
            dflag_r <= pwdata;
            dflag_dir_r <= pwdata;
        end
    end

    // Access sequencer: setup cycle, strobe held while ack is low, one idle cycle
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state_r <= EMP_IDLE;
            addr_r <= EMP_ADDR_RST;
            bank_r <= 2'h0;
            wr_r <= 1'b0;
            cond_r <= 1'b0;
            wait_r <= 4'h0;
        end
        else
        begin
            case (state_r)
                EMP_IDLE:
                begin
                    if (apb_wr && hit(paddr, EMP_OFS_CMD))
                    begin
                        addr_r <= pwdata[EMP_ADDR_W-1:0];
                        bank_r <= pwdata[EMP_CMD_BANK_LO +: 2];
                        wr_r <= pwdata[EMP_CMD_WR];
                        cond_r <= ctrl_r[EMP_CTRL_COND];
                        state_r <= EMP_SETUP;
                    end
                end
                EMP_SETUP:
                begin
                    wait_r <= 4'(EMP_STROBE_CYC);
                    state_r <= EMP_STROBE;
                end
                EMP_STROBE:
                begin
                    if (wait_r > 4'h1)
                        wait_r <= wait_r - 4'h1;
                    else if (ack)
                        state_r <= EMP_DONE;
                end
                EMP_DONE:
                    state_r <= EMP_IDLE;
                default:
                    state_r <= EMP_IDLE;
            endcase
        end
    end

    // A false condition still selects the bank but moves no data
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            rdata_r <= 32'h0000_0000;
        else if (last_cyc && !wr_r && !cond_r)
            rdata_r <= data_in;
    end

    // Bank 1 is also the flash select when booting
    assign active = busy || ctrl_r[EMP_CTRL_BOOT];

    emp_bank_dec u_dec (
        .active(active),
        .bank(ctrl_r[EMP_CTRL_BOOT] && !busy ? 2'h1 : bank_r),
        .sel_n(bank_sel_n)
    );

    assign memory_bank_select_n = bank_sel_n[1:0];
    assign ext_addr = addr_r;
    assign read_strobe_n = !strobe_on(state_r, 1'b0, wr_r, cond_r);
    assign write_strobe_n = !strobe_on(state_r, 1'b1, wr_r, cond_r);

    emp_pip_cap u_pip (
        .ref_clk(ref_clk),
        .reset(reset),
        .enable(pmux == EMP_PMUX_PIP),
        .pins(data_in),
        .clear(apb_rd && hit(paddr, EMP_OFS_PIN)),
        .word_r(pip_word),
        .fresh_r(pip_fresh)
    );

    always_comb
    begin
        data_out_nxt = 32'h0000_0000;
        data_oe_n_nxt = 32'hFFFF_FFFF;
        case (pmux)
            EMP_PMUX_EXTERNAL_MEMORY_INTERFACE_MODE:
            begin
                data_out_nxt = wdata_r;
                data_oe_n_nxt = (busy && wr_r && !cond_r) ? 32'h0000_0000 : 32'hFFFF_FFFF;
            end
            EMP_PMUX_FLAG:
            begin
                data_out_nxt = dflag_r;
                data_oe_n_nxt = ~dflag_dir_r;
            end
            EMP_PMUX_PWM:
            begin
                data_out_nxt = pwm_in;
                data_oe_n_nxt = 32'h0000_0000;
            end
            default:
            begin
                data_out_nxt = 32'h0000_0000;
                data_oe_n_nxt = 32'hFFFF_FFFF;
            end
        endcase
    end

    // Pads are fed from flops; the write drive, decoded in setup, still covers the strobe
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            data_out <= 32'h0000_0000;
            data_oe_n <= 32'hFFFF_FFFF;
        end
        else
        begin
            data_out <= data_out_nxt;
            data_oe_n <= data_oe_n_nxt;
        end
    end

    // General pins: flags by default, alternate or bank select by mode
    always_comb
    begin
        gpio_out = flag_out_r;
        gpio_oe_n = ~flag_dir_r;
        irq_req_nxt = 4'h0;
        irq_req_nxt[1:0] = gpio_in[1:0];
        if (g2_mode == EMP_GMODE_ALT)
        begin
            gpio_oe_n[2] = 1'b1;
            irq_req_nxt[2] = !gpio_in[2];
        end
        else if (g2_mode == EMP_GMODE_BANK)
        begin
            gpio_out[2] = bank_sel_n[2];
            gpio_oe_n[2] = 1'b0;
        end
        if (g3_mode == EMP_GMODE_ALT)
        begin
            gpio_out[3] = timer_expired_output;
            gpio_oe_n[3] = 1'b0;
        end
        else if (g3_mode == EMP_GMODE_BANK)
        begin
            gpio_out[3] = bank_sel_n[3];
            gpio_oe_n[3] = 1'b0;
        end
    end

    // Interrupt requests leave from a flop, one cycle behind the pins
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            irq_req <= 4'h0;
        else
            irq_req <= irq_req_nxt;
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit(paddr, EMP_OFS_CTRL))
            rd_mux = ctrl_r;
        else if (hit(paddr, EMP_OFS_CMD))
            rd_mux = {5'h00, wr_r, bank_r, addr_r};
        else if (hit(paddr, EMP_OFS_WDATA))
            rd_mux = wdata_r;
        else if (hit(paddr, EMP_OFS_RDATA))
            rd_mux = rdata_r;
        else if (hit(paddr, EMP_OFS_STAT))
            rd_mux = {27'h000_0000, pip_fresh, !ack, state_r, busy};
        else if (hit(paddr, EMP_OFS_FLAG))
            rd_mux = {24'h00_0000, flag_dir_r, gpio_in};
        else if (hit(paddr, EMP_OFS_PIN))
            rd_mux = pip_word;
    end

    // Read data from a flop, loaded in the setup cycle
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= rd_mux;
    end
endmodule // emp_port

// File: emp_port_checker.sv
// Purpose: Pin timing checks for the external memory port
// Assumes: One clock, async active-high reset
// Notes: Bound to emp_port below
`timescale 1ns/1ps
module emp_port_checker
    import emp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [EMP_ADDR_W-1:0] ext_addr,
    input wire logic [EMP_DATA_W-1:0] data_oe_n,
    input wire logic ack,
    input wire logic [1:0] memory_bank_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [EMP_GPIO-1:0] gpio_oe_n
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    wire logic stb = !(read_strobe_n && write_strobe_n);
    sequence s_wait;
        stb && !ack;
    endsequence
    sequence s_done;
        stb && ack;
    endsequence
    a_reset_idle: assert property ($fell(reset) |-> &data_oe_n && &gpio_oe_n)
        else $error("pins not idle after reset");
    a_one_strobe: assert property (read_strobe_n || write_strobe_n)
        else $error("both strobes low");
    a_wait_hold: assert property (s_wait |=> stb)
        else $error("strobe ended while ack low");
    a_ack_ends: assert property (s_done |=> !stb)
        else $error("strobe held after ack high");
    a_addr_setup: assert property ($rose(stb) |-> $stable(ext_addr))
        else $error("address moved as strobe began");
    a_addr_hold: assert property (stb && $past(stb) |-> $stable(ext_addr))
        else $error("address moved during strobe");
    a_one_bank: assert property ($onehot0(~memory_bank_select_n))
        else $error("two bank selects low");
    a_write_drive: assert property (!write_strobe_n |-> data_oe_n == '0)
        else $error("data not driven in write");
    a_read_float: assert property (!read_strobe_n |-> &data_oe_n)
        else $error("data driven in read");
    a_sel_release: assert property (s_done |-> ##2 memory_bank_select_n[0])
        else $error("bank 0 select held after access");
endmodule // emp_port_checker
bind emp_port emp_port_checker i_chk (.ref_clk, .reset, .ext_addr, .data_oe_n, .ack,
    .memory_bank_select_n, .read_strobe_n, .write_strobe_n, .gpio_oe_n);

// File: emp_mem_model.sv
// Purpose: Asynchronous memory on the far side of the port
// Assumes: Word index from address bits 3:0
// Notes: Wait states set by the bench
`timescale 1ns/1ps
module emp_mem_model
    import emp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [EMP_ADDR_W-1:0] ext_addr,
    input wire logic [EMP_DATA_W-1:0] data_out,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [3:0] wait_cyc,
    input wire logic pin_en,
    input wire logic [EMP_DATA_W-1:0] pin_val,
    output logic ack,
    output logic [EMP_DATA_W-1:0] data_in
);
    logic [EMP_DATA_W-1:0] mem_r [16];
    logic [3:0] cnt_r;
    wire logic stb = !(read_strobe_n && write_strobe_n);
    // Ack idles high on its pull-up
    assign ack = !stb || cnt_r >= wait_cyc;
    // Released data pins float up to the pull-up level
    assign data_in = pin_en ? pin_val : !read_strobe_n ? mem_r[ext_addr[3:0]] : '1;
    always_ff @(posedge ref_clk)
    begin
        cnt_r <= stb ? cnt_r + 4'h1 : 4'h0;
        if (!write_strobe_n && ack)
            mem_r[ext_addr[3:0]] <= data_out;
    end
endmodule // emp_mem_model

// File: external_memory_port_pins_tb_top.sv
// Purpose: Self-checking bench for emp_port
// Assumes: APB with pready high, memory model on the pins
// Notes: Selects of banks 2 and 3 come out on general pins
`timescale 1ns/1ps
module external_memory_port_pins_tb_top
    import emp_pkg::*;
;
    logic ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pin_en = 0, timer = 0;
    logic mon_clr = 0, rs_q = 1, ws_q = 1, pready, pslverr, rs_n, ws_n, ack, err, w_op;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, pin_val = 0, pwm = 32'h0F0F_A5A5, prdata, rd;
    logic [31:0] data_in, data_out, data_oe_n;
    logic [23:0] ext_addr;
    logic [1:0] msel_n, b;
    logic [3:0] gpio_in = 4'h0, wait_cyc = 4'h0, gpio_out, gpio_oe_n, irq, sel_seen;
    int bad_count = 0, tests_run = 0, rd_cnt = 0, wr_cnt = 0, r0, w0;
    always #50 ref_clk = ~ref_clk;
    emp_port i_dut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ext_addr, .data_in, .data_out, .data_oe_n, .ack,
        .memory_bank_select_n(msel_n), .read_strobe_n(rs_n), .write_strobe_n(ws_n),
        .gpio_in, .gpio_out, .gpio_oe_n, .pwm_in(pwm), .timer_expired_output(timer),
        .irq_req(irq));
    emp_mem_model i_mem (.ref_clk, .ext_addr, .data_out, .read_strobe_n(rs_n),
        .write_strobe_n(ws_n), .wait_cyc, .pin_en, .pin_val, .ack, .data_in);
    // Gathers every select seen low since the last clear
    always @(posedge ref_clk)
    begin
        sel_seen <= mon_clr ? 4'hF : sel_seen & {gpio_out[3:2] | gpio_oe_n[3:2], msel_n};
        rs_q <= rs_n;
        ws_q <= ws_n;
        if (rs_q && !rs_n) rd_cnt <= rd_cnt + 1;
        if (ws_q && !ws_n) wr_cnt <= wr_cnt + 1;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Waits for pready however long it takes; only the watchdog ends a hang
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // Polls busy; no second command may start before it clears
    task run(input logic w, input logic [1:0] bk, input logic [23:0] a);
        @(posedge ref_clk);
        mon_clr <= 1;
        apb(1, EMP_OFS_CMD, {5'h0, w, bk, a});
        mon_clr <= 0;
        do apb(0, EMP_OFS_STAT, 0); while (rd[0] !== 1'b0);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #2_000_000;
        bad_count++;
        finish_test;
    end
    initial
    begin
        repeat (3) @(posedge ref_clk);
        reset <= 0;
        check(data_oe_n, '1);
        check(32'({gpio_oe_n, msel_n, rs_n, ws_n}), 32'hFF);
        apb(0, EMP_OFS_CTRL, 0);
        check(rd, EMP_CTRL_RST);
        apb(0, 8'h1C, 0);
        check(32'(err), 32'h1);
        $display("test reset done");
        apb(1, EMP_OFS_CTRL, 32'h28);
        for (int i = 0; i < 8; i++)
        begin
            b = i[1:0];
            w_op = !i[2];
            wait_cyc <= {2'h0, b};
            r0 = rd_cnt;
            w0 = wr_cnt;
            if (w_op) apb(1, EMP_OFS_WDATA, 32'hC0DE_0000 | b);
            run(w_op, b, 24'h10 + b);
            check(32'(ext_addr), 32'h10 + b);
            check(32'(sel_seen ^ (4'h1 << b)), 32'hF);
            check(w_op ? wr_cnt - w0 : rd_cnt - r0, 1);
            if (!w_op) apb(0, EMP_OFS_RDATA, 0);
            if (!w_op) check(rd, 32'hC0DE_0000 | b);
        end
        $display("test banks done");
        apb(1, EMP_OFS_CTRL, 32'h68);
        r0 = rd_cnt;
        run(0, 2'h1, 24'h3);
        check(rd_cnt - r0, 0);
        check(32'(sel_seen ^ 4'h2), 32'hF);
        apb(1, EMP_OFS_CTRL, 32'h80);
        @(posedge ref_clk);
        check(32'(msel_n), 32'h1);
        $display("test select done");
        apb(1, EMP_OFS_CTRL, 32'h1);
        pin_en <= 1;
        pin_val <= 32'h1234_5678;
        repeat (2) @(posedge ref_clk);
        apb(0, EMP_OFS_PIN, 0);
        check(rd, 32'h1234_5678);
        pin_en <= 0;
        timer <= 1;
        apb(1, EMP_OFS_CTRL, 32'h17);
        // Data pins and interrupt requests come from flops, one edge behind the mode
        repeat (2) @(posedge ref_clk);
        check(data_out, pwm);
        check(data_oe_n, 32'h0);
        check(32'(irq[2]), 32'h1);
        check(32'({gpio_oe_n[3], gpio_out[3]}), 32'h1);
        $display("test pin modes done");
        gpio_in <= 4'hA;
        apb(1, EMP_OFS_CTRL, 32'h2);
        apb(1, EMP_OFS_PIN, 32'hF0);
        apb(1, EMP_OFS_FLAG, 32'hF5);
        apb(0, EMP_OFS_FLAG, 0);
        check(rd, 32'hFA);
        check(32'({gpio_oe_n, gpio_out}), 32'h05);
        check(32'(irq), 32'h2);
        check(data_out, 32'hF0);
        check(data_oe_n, 32'hFFFF_FF0F);
        $display("test flags done");
        apb(1, EMP_OFS_CTRL, 32'h0);
        wait_cyc <= 4'h8;
        apb(1, EMP_OFS_CMD, {5'h0, 1'b0, 2'h0, 24'h12});
        apb(1, EMP_OFS_CMD, {5'h0, 1'b1, 2'h3, 24'h7});
        check(32'(err), 32'h1);
        apb(0, EMP_OFS_STAT, 0);
        check(rd & 32'hF, 32'hD);
        do apb(0, EMP_OFS_STAT, 0); while (rd[0] !== 1'b0);
        check(32'(ext_addr), 32'h12);
        apb(0, EMP_OFS_RDATA, 0);
        check(rd, 32'hC0DE_0002);
        $display("test refused command done");
        finish_test;
    end
endmodule // external_memory_port_pins_tb_top
